// [core/adcsq_coder.sv]
`timescale 1ns/1ps
module adcsq_coder
    import adcsq_pkg::*;
(
    // Link clock
    input wire logic sclk_i,
    // Conversion path
    adcsq_conv_if.coder cv
);

    logic [VIN_BITS-1:0]  vin_sync [NUM_CH]; // Synchronised input levels
    logic [VIN_BITS-1:0]  sel_vin;           // Level of the routed channel
    logic [CODE_BITS-1:0] raw_one;           // Code over one span
    logic [CODE_BITS-1:0] raw_two;           // Code over the doubled span
    logic [CODE_BITS-1:0] raw;               // Straight binary code
    logic [CODE_BITS-1:0] coded;             // Code after coding select

    // Two stages per channel, the first read only by the second
    for (genvar g = 0; g < NUM_CH; g++) begin : g_sync
        logic [VIN_BITS-1:0] s1_q;
        logic [VIN_BITS-1:0] s2_q;
        always_ff @(posedge sclk_i) begin
            s1_q <= cv.vin[g*VIN_BITS +: VIN_BITS];
            s2_q <= s1_q;
        end
        assign vin_sync[g] = s2_q;
    end

    // Input multiplexer driven by the channel address
    assign sel_vin = vin_sync[cv.chan];
    // One step per REF/4096, clipped at the span top
    assign raw_one = sel_vin[VIN_BITS-1] ? FULL_CODE : sel_vin[CODE_BITS-1:0];
    // Doubled span halves the resolution per input step
    assign raw_two = sel_vin[VIN_BITS-1:1];
    assign raw     = cv.range_one ? raw_one : raw_two;
    // Flipping the top bit turns offset binary into twos complement
    assign coded   = cv.twos ? (raw ^ MID_CODE) : raw;
    // Test pattern lets software check the framing without an input
    assign cv.code = cv.test_en ? TEST_CODE : coded;

    a_bipolar_zero: assert property (@(posedge sclk_i) disable iff (cv.rst)
        (!cv.test_en && !cv.range_one && cv.twos && sel_vin == VIN_BITS'(LSB_STEPS))
        |-> cv.code == '0)
        else $error("mid span input did not give zero code");

    a_range_clip: assert property (@(posedge sclk_i) disable iff (cv.rst)
        (!cv.test_en && cv.range_one && !cv.twos && sel_vin[VIN_BITS-1])
        |-> cv.code == FULL_CODE)
        else $error("input above one span did not clip");

endmodule

// [core/adcsq_conv_if.sv]
`timescale 1ns/1ps
interface adcsq_conv_if import adcsq_pkg::*; ;
    logic [NUM_CH*VIN_BITS-1:0] vin;       // Raw input levels, all channels
    logic [CH_BITS-1:0]         chan;      // Channel being converted
    logic                       range_one; // One reference span when high
    logic                       twos;      // Twos complement coding when high
    logic                       test_en;   // Fixed pattern instead of input
    logic                       rst;       // Link domain reset
    logic [CODE_BITS-1:0]       code;      // Coded result

    modport top   (output vin, chan, range_one, twos, test_en, rst, input code);
    modport coder (input vin, chan, range_one, twos, test_en, rst, output code);
endinterface

// [core/adcsq_pkg.sv]
package adcsq_pkg;

    // Link word geometry
    localparam int CTRL_BITS  = 12;  // Control bits shifted in per transfer
    localparam int FRAME_BITS = 16;  // Result word length
    localparam int CODE_BITS  = 12;  // Conversion result width
    localparam int CH_BITS    = 2;   // Channel address width
    localparam int NUM_CH     = 4;   // Analog inputs
    localparam int VIN_BITS   = 13;  // Input level in steps of REF/4096, up to twice REF
    localparam int LSB_STEPS  = 4096; // Steps across one reference span

    // Control word bit positions, first bit shifted in is the top one
    localparam int CTL_WRITE  = 11;
    localparam int CTL_SEQ_HI = 10;
    localparam int CTL_CH_HI  = 7;
    localparam int CTL_CH_LO  = 6;
    localparam int CTL_PM_HI  = 5;
    localparam int CTL_PM_LO  = 4;
    localparam int CTL_SEQ_LO = 3;
    localparam int CTL_RANGE  = 1;
    localparam int CTL_CODING = 0;

    // Sequence field codes, high bit then low bit
    localparam logic [1:0] SEQ_KEEP = 2'h2;
    localparam logic [1:0] SEQ_RUN  = 2'h3;

    // Falling edge numbers inside a transfer
    localparam logic [4:0] EDGE_CTRL  = 5'h0c;
    localparam logic [4:0] EDGE_TRACK = 5'h0e;
    localparam logic [4:0] EDGE_LAST  = 5'h10;

    // Codes
    localparam logic [CODE_BITS-1:0] FULL_CODE = 12'hfff;
    localparam logic [CODE_BITS-1:0] MID_CODE  = 12'h800;
    localparam logic [CODE_BITS-1:0] TEST_CODE = 12'ha5a;
    localparam logic [CTRL_BITS-1:0] CTRL_RST  = 12'h030;

    // Avalon byte addresses
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_RESULT = 4'h4;
    localparam logic [3:0] ADDR_FRAMES = 4'h8;
    localparam logic [3:0] ADDR_TEST   = 4'hc;

endpackage

// [core/adcsq_top.sv]
`timescale 1ns/1ps
module adcsq_top
    import adcsq_pkg::*;
(
    // System clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    // Avalon-MM slave
    input  wire logic [3:0]                 avs_address_i,
    input  wire logic                       avs_read_i,
    input  wire logic                       avs_write_i,
    input  wire logic [31:0]                avs_writedata_i,
    input  wire logic [3:0]                 avs_byteenable_i,
    output logic      [31:0]                avs_readdata_o,
    output logic                            avs_waitrequest_o,
    // Serial link
    input  wire logic                       sclk_i,
    input  wire logic                       cs_n_i,
    input  wire logic                       din_i,
    output logic                            dout_o,
    output logic                            dout_oe_o,
    // Analog side
    input  wire logic [NUM_CH*VIN_BITS-1:0] vin_i,
    output logic      [CH_BITS-1:0]         chan_sel_o,
    output logic                            hold_o
);

    adcsq_conv_if cv ();

    // Link domain reset and configuration crossing
    logic                  rst_s1_q;   // Reset synchroniser, first stage
    logic                  rst_s2_q;   // Reset as seen by the link
    logic                  tst_s1_q;   // Test enable synchroniser, first stage
    logic                  tst_s2_q;   // Test enable as seen by the link

    // Per-transfer state, cleared while chip select is high
    logic [4:0]            bit_cnt_q;  // Falling edges seen in this transfer
    logic [CTRL_BITS-2:0]  din_sh_q;   // Control bits gathered so far
    logic [FRAME_BITS-1:0] shift_q;    // Result bits still to send
    logic                  dout_q;     // Serial output bit
    logic                  oe_q;       // Serial output driven
    logic                  hold_q;     // Track-and-hold in hold

    // State kept across transfers
    logic [CTRL_BITS-1:0]  ctrl_q;     // Stored control word
    logic                  seq_on_q;   // Automatic sequence running
    logic [CH_BITS-1:0]    final_ch_q; // Last channel of the sequence
    logic [CH_BITS-1:0]    conv_ch_q;  // Channel for the current transfer
    logic [FRAME_BITS-1:0] res_q;      // Word of the current transfer
    logic                  frm_tgl_q;  // Flips at each complete transfer
    logic [28:0]           snap_q;     // Status snapshot for software

    // System domain state
    logic                  ft_s1_q;    // Transfer toggle, first stage
    logic                  ft_s2_q;    // Transfer toggle, synchronised
    logic                  ft_s3_q;    // Transfer toggle, delayed for edge
    logic [28:0]           stat_q;     // Snapshot copy in system domain
    logic [15:0]           frames_q;   // Complete transfers counted
    logic                  test_en_q;  // Software test pattern enable
    logic                  wait_q;     // Waitrequest
    logic [31:0]           rdata_q;    // Read data

    // Decoded link terms
    logic                  link_rst;
    logic                  frame_on;
    logic [4:0]            edge_no;
    logic                  at_first;
    logic                  at_ctrl;
    logic                  at_track;
    logic                  frame_done;
    logic                  in_ctrl;
    logic [FRAME_BITS-1:0] frame_word;
    logic [CTRL_BITS-1:0]  ctrl_word;
    logic                  wr_bit;
    logic [1:0]            seq_field;
    logic [CH_BITS-1:0]    new_ch;
    logic [CH_BITS-1:0]    ctrl_ch;
    logic                  ctrl_take;
    logic                  seq_start;
    logic                  seq_keep;
    logic                  seq_stop;
    logic [CH_BITS-1:0]    step_ch;
    logic [CH_BITS-1:0]    next_ch;

    // Next values
    logic [4:0]            bit_cnt_d;
    logic [CTRL_BITS-2:0]  din_sh_d;
    logic [FRAME_BITS-1:0] shift_d;
    logic                  dout_d;
    logic                  hold_d;
    logic [CTRL_BITS-1:0]  ctrl_d;
    logic                  seq_on_d;
    logic [CH_BITS-1:0]    final_d;
    logic [CH_BITS-1:0]    conv_d;
    logic [FRAME_BITS-1:0] res_d;

    // Decoded bus terms
    logic                  bus_req;
    logic                  bus_take;
    logic                  new_frame;
    logic                  hit_status;
    logic                  hit_result;
    logic                  hit_frames;
    logic                  hit_test;
    logic                  wr_test;
    logic [31:0]           rdata_d;

    // Converter path hookup
    assign cv.vin       = vin_i;
    assign cv.chan      = conv_ch_q;
    assign cv.range_one = ctrl_q[CTL_RANGE];
    assign cv.twos      = ctrl_q[CTL_CODING];
    assign cv.test_en   = tst_s2_q;
    assign cv.rst       = link_rst;

    adcsq_coder u_coder (
        .sclk_i (sclk_i),
        .cv     (cv)
    );

    // Reset and test enable into the link domain; only valid while the clock runs
    always_ff @(negedge sclk_i) begin
        rst_s1_q <= srst_i;
        rst_s2_q <= rst_s1_q;
        tst_s1_q <= test_en_q;
        tst_s2_q <= tst_s1_q;
    end
    assign link_rst = rst_s2_q;

    // Transfer position
    assign frame_on   = ~cs_n_i;
    assign edge_no    = bit_cnt_q + 5'h01;
    assign at_first   = frame_on && (bit_cnt_q == 5'h00);
    assign at_ctrl    = frame_on && (edge_no == EDGE_CTRL);
    assign at_track   = edge_no == EDGE_TRACK;
    assign frame_done = bit_cnt_q == EDGE_LAST;
    assign in_ctrl    = edge_no <= EDGE_CTRL;

    // Result word: two zeros, channel tag, then the code
    assign frame_word = {2'h0, conv_ch_q, cv.code};

    // Counter stops after the sixteenth edge
    assign bit_cnt_d = frame_done ? bit_cnt_q : edge_no;
    // Control bits shift in on the first twelve edges
    assign din_sh_d  = in_ctrl ? {din_sh_q[CTRL_BITS-3:0], din_i} : din_sh_q;
    // Top bit is never driven; the next one goes out now
    assign shift_d   = at_first ? {frame_word[FRAME_BITS-3:0], 2'h0}
                                : {shift_q[FRAME_BITS-2:0], 1'h0};
    assign dout_d    = at_first ? frame_word[FRAME_BITS-2] : shift_q[FRAME_BITS-1];
    // Hold from transfer start until the fourteenth edge
    assign hold_d    = at_first ? 1'h1 : (at_track ? 1'h0 : hold_q);

    // Per-transfer logic, chip select high ends the transfer at once
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_q <= '0;
            din_sh_q  <= '0;
            shift_q   <= '0;
            dout_q    <= 1'h0;
            oe_q      <= 1'h0;
            hold_q    <= 1'h0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            din_sh_q  <= din_sh_d;
            shift_q   <= shift_d;
            dout_q    <= dout_d;
            oe_q      <= 1'h1;
            hold_q    <= hold_d;
        end
    end

    // Control word fields, last bit taken straight from the pin
    assign ctrl_word = {din_sh_q, din_i};
    assign wr_bit    = ctrl_word[CTL_WRITE];
    assign seq_field = {ctrl_word[CTL_SEQ_HI], ctrl_word[CTL_SEQ_LO]};
    assign new_ch    = {ctrl_word[CTL_CH_HI], ctrl_word[CTL_CH_LO]};
    assign ctrl_ch   = {ctrl_q[CTL_CH_HI], ctrl_q[CTL_CH_LO]};

    // Write bit low leaves every stored control bit alone
    assign ctrl_take = at_ctrl && wr_bit;
    assign seq_start = ctrl_take && (seq_field == SEQ_RUN);
    assign seq_keep  = ctrl_take && (seq_field == SEQ_KEEP);
    assign seq_stop  = ctrl_take && !seq_start && !seq_keep;

    // Ascend to the final channel then wrap; final zero stays on zero
    assign step_ch = (conv_ch_q == final_ch_q) ? '0 : conv_ch_q + 2'h1;

    // Channel for the next transfer
    assign next_ch = seq_start ? '0
                   : seq_stop  ? new_ch
                   : seq_on_q  ? step_ch
                   : ctrl_take ? new_ch : ctrl_ch;

    assign ctrl_d   = ctrl_take ? ctrl_word : ctrl_q;
    assign seq_on_d = seq_start ? 1'h1 : (seq_stop ? 1'h0 : seq_on_q);
    // A keep write must not move the end of the running sequence
    assign final_d  = seq_start ? new_ch : final_ch_q;
    assign conv_d   = at_ctrl ? next_ch : conv_ch_q;
    // Input captured at the first edge of the transfer
    assign res_d    = at_first ? frame_word : res_q;

    // State kept across transfers
    always_ff @(negedge sclk_i) begin
        if (link_rst) begin
            ctrl_q     <= CTRL_RST;
            seq_on_q   <= 1'h0;
            final_ch_q <= '0;
            conv_ch_q  <= '0;
            res_q      <= '0;
            frm_tgl_q  <= 1'h0;
            snap_q     <= '0;
        end else begin
            ctrl_q     <= ctrl_d;
            seq_on_q   <= seq_on_d;
            final_ch_q <= final_d;
            conv_ch_q  <= conv_d;
            res_q      <= res_d;
            // Snapshot changes only here, so it is stable when the toggle is seen
            if (frame_on && edge_no == EDGE_LAST) begin
                frm_tgl_q <= ~frm_tgl_q;
                snap_q    <= {seq_on_q, ctrl_q, res_q};
            end
        end
    end

    assign dout_o     = dout_q;
    assign dout_oe_o  = oe_q;
    assign hold_o     = hold_q;
    assign chan_sel_o = conv_ch_q;

    // Link assertions
    sequence s_ctrl_write;
        at_ctrl && wr_bit;
    endsequence

    sequence s_seq_idle_step;
        at_ctrl && seq_on_q && !seq_start && !seq_stop;
    endsequence

    a_hold_window: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (bit_cnt_q >= 5'h01 && bit_cnt_q < EDGE_TRACK) |-> hold_q)
        else $error("hold dropped before the fourteenth edge");

    a_track_back: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (bit_cnt_q == EDGE_TRACK) |-> !hold_q ##1 (!hold_q && bit_cnt_q == 5'h0f))
        else $error("track not resumed at the fourteenth edge");

    a_word_bits: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (bit_cnt_q >= 5'h01 && bit_cnt_q < EDGE_LAST)
        |-> dout_q == res_q[FRAME_BITS-1-int'(bit_cnt_q)])
        else $error("serial bit differs from the result word");

    a_word_tag: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (bit_cnt_q == 5'h01) |-> (res_q[FRAME_BITS-1 -: 2] == 2'h0
                              && res_q[CODE_BITS +: CH_BITS] == conv_ch_q))
        else $error("word lacks zeros or channel tag");

    a_seq_start: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (s_ctrl_write and (seq_field == SEQ_RUN)) |=> (conv_ch_q == '0 && seq_on_q))
        else $error("sequence did not start on channel zero");

    a_seq_stop: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (s_ctrl_write and (seq_field != SEQ_RUN && seq_field != SEQ_KEEP))
        |=> (!seq_on_q && conv_ch_q == $past(new_ch)))
        else $error("sequence not ended by write");

    a_seq_wrap: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (s_seq_idle_step and (conv_ch_q == final_ch_q)) |=> conv_ch_q == '0)
        else $error("sequence did not wrap to zero");

    a_seq_step: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (s_seq_idle_step and (conv_ch_q != final_ch_q))
        |=> conv_ch_q == $past(conv_ch_q) + 2'h1)
        else $error("sequence did not step by one");

    a_ctrl_keep: assert property (@(negedge sclk_i) disable iff (cs_n_i || link_rst)
        (at_ctrl && !wr_bit) |=> $stable(ctrl_q) ##1 $stable(ctrl_q))
        else $error("control changed without write bit");

    // Transfer toggle into the system domain
    assign new_frame = ft_s2_q ^ ft_s3_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ft_s1_q  <= 1'h0;
            ft_s2_q  <= 1'h0;
            ft_s3_q  <= 1'h0;
            stat_q   <= '0;
            frames_q <= '0;
        end else begin
            ft_s1_q <= frm_tgl_q;
            ft_s2_q <= ft_s1_q;
            ft_s3_q <= ft_s2_q;
            // Counter wraps silently; software must read often enough
            if (new_frame) begin
                stat_q   <= snap_q;
                frames_q <= frames_q + 16'h0001;
            end
        end
    end

    // Bus decode, one wait cycle per access
    assign bus_req    = avs_read_i | avs_write_i;
    assign bus_take   = bus_req && wait_q;
    assign hit_status = avs_address_i == ADDR_STATUS;
    assign hit_result = avs_address_i == ADDR_RESULT;
    assign hit_frames = avs_address_i == ADDR_FRAMES;
    assign hit_test   = avs_address_i == ADDR_TEST;
    assign wr_test    = avs_write_i && !wait_q && hit_test && avs_byteenable_i[0];

    // Unmapped addresses read zero
    assign rdata_d = hit_status ? {19'h0, stat_q[28:16]}
                   : hit_result ? {16'h0, stat_q[15:0]}
                   : hit_frames ? {16'h0, frames_q}
                   : hit_test   ? {31'h0, test_en_q} : 32'h0;

    // Bus slave registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wait_q    <= 1'h1;
            rdata_q   <= '0;
            test_en_q <= 1'h0;
        end else begin
            wait_q <= ~bus_take;
            if (avs_read_i && wait_q) begin
                rdata_q <= rdata_d;
            end
            if (wr_test) begin
                test_en_q <= avs_writedata_i[0];
            end
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    a_wait_single: assert property (@(posedge clk_i) disable iff (srst_i)
        (bus_req && wait_q) |=> (!wait_q ##1 wait_q))
        else $error("waitrequest not low for exactly one cycle");

endmodule

// [tb/adcsq_host.sv]
`timescale 1ns/1ps
// Host serial port: clock idles high and stands still outside frames, except for the idle clocks around reset
module adcsq_host (
    // Link pins toward the device
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      din_o,
    // Device answers
    input  wire logic dout_i,
    input  wire logic oe_i,
    input  wire logic hold_i
);
    // Idle levels from time zero, device deselected
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    // Free clocks with select high; only used around reset
    task automatic idle(input int n);
        repeat (n) begin
            #7.5 sclk_o = 1'b0;
            #7.5 sclk_o = 1'b1;
        end
    endtask
    // One frame: control word out, result word and hold trace back
    task automatic xfer(input logic [11:0] ctl, output logic [15:0] word,
                        output logic [15:0] hv);
        word   = 16'h0;
        hv     = 16'h0;
        cs_n_o = 1'b0;
        din_o  = ctl[11];
        for (int k = 1; k <= 16; k++) begin
            #7.5 sclk_o = 1'b0;
            #7.5 sclk_o = 1'b1;
            hv[k-1] = hold_i;
            // Top bit is undriven, so only fifteen are read; a released line reads inverted
            if (k < 16) begin
                word[15-k] = oe_i ? dout_i : ~dout_i;
            end
            // Past the control word the line toggles so nothing stale looks valid
            din_o = (k < 12) ? ctl[11-k] : ~din_o;
        end
        #7.5 cs_n_o = 1'b1;
        #45;
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import adcsq_pkg::*;
    logic                  clk_i = 1'b0;
    logic                  srst_i = 1'b1;
    logic [3:0]            avs_address_i = 4'h0;
    logic                  avs_read_i = 1'b0;
    logic                  avs_write_i = 1'b0;
    logic [31:0]           avs_writedata_i = 32'h0;
    logic [3:0]            avs_byteenable_i = 4'hf;
    logic [31:0]           avs_readdata_o;
    logic [31:0]           rd;
    logic                  avs_waitrequest_o;
    logic                  sclk, cs_n, din, dout_o, dout_oe_o, hold_o;
    logic [1:0]            chan_sel_o;
    logic [VIN_BITS-1:0]   lvl [NUM_CH] = '{13'h1000, 13'h0123, 13'h1fff, 13'h0800};
    wire  [NUM_CH*VIN_BITS-1:0] vin = {lvl[3], lvl[2], lvl[1], lvl[0]};
    int                    num_errors = 0;
    int                    n_checks = 0;
    int                    cycles = 0;
    int                    prev;
    logic                  rng = 1'b0; // Settings in force after reset
    logic                  tw = 1'b0;
    logic                  tp = 1'b0; // Test pattern expected on the link
    logic [15:0]           word, hv;

    // System clock, 25 ns
    always #12.5 clk_i = ~clk_i;

    adcsq_top u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout_o),
        .dout_oe_o(dout_oe_o), .vin_i(vin), .chan_sel_o(chan_sel_o), .hold_o(hold_o));
    adcsq_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
        .dout_i(dout_o), .oe_i(dout_oe_o), .hold_i(hold_o));

    // Control word builder
    function automatic logic [11:0] ctl(logic w, logic [1:0] sq, logic [1:0] ch,
                                        logic r, logic t);
        return {w, sq[1], 2'b00, ch, 2'b11, sq[0], 1'b0, r, t};
    endfunction
    // Expected code under the settings now in force
    function automatic logic [11:0] code(logic [12:0] v);
        logic [11:0] c;
        c = rng ? ((v >= 13'h1000) ? 12'hfff : v[11:0]) : v[12:1];
        return tp ? TEST_CODE : {c[11] ^ tw, c[10:0]};
    endfunction
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One frame; a write takes effect for the frame after it
    task automatic xf(input logic [11:0] c, input logic [1:0] ch);
        `CHK("channel out", ch, chan_sel_o)
        u_host.xfer(c, word, hv);
        `CHK("result word", {2'b00, ch, code(lvl[ch])}, word)
        `CHK("hold trace", 16'h1fff, hv)
        if (c[11]) begin
            rng = c[1];
            tw  = c[0];
        end
    endtask
    // Avalon access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= wd;
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // Hang guard, well above the run length
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        // Link clock must run through reset
        fork
            repeat (8) @(posedge clk_i);
            u_host.idle(12);
        join
        srst_i <= 1'b0;
        u_host.idle(4);
        // Snapshot stays clear until a transfer completes
        av(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status reset", 32'h0, rd)
        av(1'b0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        // Lane zero disabled, so the write is ignored
        avs_byteenable_i <= 4'he;
        av(1'b1, ADDR_TEST, 32'h1);
        avs_byteenable_i <= 4'hf;
        av(1'b0, ADDR_TEST, 32'h0);
        `CHK("test lane off", 32'h0, rd)
        av(1'b1, ADDR_TEST, 32'h1);
        av(1'b0, ADDR_TEST, 32'h0);
        `CHK("test bit", 1'b1, rd[0])
        // Enable crosses during a transfer, so one unchecked frame each way
        u_host.xfer(12'h000, word, hv);
        tp = 1'b1;
        xf(12'h000, 2'd0);
        av(1'b1, ADDR_TEST, 32'h0);
        u_host.xfer(12'h000, word, hv);
        tp = 1'b0;
        // Coding and range on the reference level of channel 0
        xf(ctl(1'b1, 2'b00, 2'd2, 1'b1, 1'b0), 2'd0);
        prev = 2;
        for (int i = 0; i < 4; i++) begin
            xf(ctl(1'b1, 2'b01, 2'd0, i[1], i[0]), prev[1:0]);
            prev = 0;
        end
        // Each write picks the next channel
        for (int i = 0; i < 4; i++) begin
            xf(ctl(1'b1, 2'b00, i[1:0], 1'b1, 1'b0), prev[1:0]);
            prev = i;
        end
        xf(ctl(1'b1, SEQ_RUN, 2'd2, 1'b1, 1'b0), 2'd3);
        xf(12'h000, 2'd0);
        xf(12'h000, 2'd1);
        xf(ctl(1'b1, SEQ_KEEP, 2'd2, 1'b1, 1'b1), 2'd2);
        xf(12'h000, 2'd0);
        av(1'b0, ADDR_STATUS, 32'h0);
        `CHK("running", 1'b1, rd[12])
        `CHK("status word", ctl(1'b1, SEQ_KEEP, 2'd2, 1'b1, 1'b1), rd[11:0])
        xf(ctl(1'b1, 2'b00, 2'd3, 1'b1, 1'b0), 2'd1);
        xf(12'h000, 2'd3);
        xf(ctl(1'b1, SEQ_RUN, 2'd0, 1'b1, 1'b0), 2'd3);
        xf(12'h000, 2'd0);
        xf(12'h000, 2'd0);
        av(1'b0, ADDR_RESULT, 32'h0);
        `CHK("result reg", 16'h0fff, rd[15:0])
        av(1'b0, ADDR_FRAMES, 32'h0);
        `CHK("frames", 16'h0016, rd[15:0])
        print_verdict();
    end
endmodule
